// ---- hdl/rspc_pkg.sv ----
package rspc_pkg;
  // ************************************************************
  // config bus map
  // ************************************************************
  localparam logic [31:0] RSPC_REGION_BASE = 32'h01b3f000;
  localparam logic [31:0] RSPC_REGION_SIZE = 32'h00001000;
  localparam logic [11:0] RSPC_PERIPH_SEL_OFS = 12'h000;
  localparam logic [11:0] RSPC_DEV_STATUS_OFS = 12'h004;
  localparam logic [11:0] RSPC_SCAN_ID_OFS = 12'h008;
  localparam logic [31:0] RSPC_RSVD_READ_VAL = 32'h00000000;
  localparam int RSPC_VP2_EN_BIT = 6;
  localparam logic RSPC_VP2_EN_RST = 1'b0;
  // device status layout (packed straps)
  localparam int RSPC_ST_ENDIAN_BIT = 0;
  localparam int RSPC_ST_BOOT_LSB = 3;
  localparam int RSPC_ST_CLK_LSB = 1;
  localparam int RSPC_ST_EEAI_BIT = 5;
  localparam int RSPC_ST_SPEED_BIT = 6;
  localparam int RSPC_ST_WIDTH_BIT = 7;
  localparam int RSPC_ST_MAC_BIT = 8;
  localparam int RSPC_ST_PCI_BIT = 9;
  // ************************************************************
  // strap encodings
  // ************************************************************
  localparam logic RSPC_ENDIAN_BIG = 1'b0;
  localparam logic [1:0] RSPC_BOOT_NONE = 2'h0;
  localparam logic [1:0] RSPC_BOOT_HOST_PCI = 2'h1;
  localparam logic [1:0] RSPC_BOOT_EXTMEM = 2'h3;
  localparam logic [1:0] RSPC_CLK_INPUT = 2'h0;
  localparam logic [1:0] RSPC_CLK_DIV4 = 2'h1;
  localparam logic [1:0] RSPC_CLK_DIV6 = 2'h2;
  localparam logic [1:0] RSPC_SEL_HOST = 2'h0;
  localparam logic [1:0] RSPC_SEL_MAC = 2'h1;
  localparam logic [1:0] RSPC_SEL_PCI = 2'h2;
  localparam int RSPC_HOST_HALF = 16;
  localparam int RSPC_HOST_FULL = 32;
  typedef enum logic [1:0] {
    RSPC_BOOT_MODE_NONE,
    RSPC_BOOT_MODE_HOST,
    RSPC_BOOT_MODE_PCI,
    RSPC_BOOT_MODE_EXTMEM
  } rspc_boot_t;
endpackage : rspc_pkg

// ---- hdl/rspc_strap_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for the strap pins
module rspc_strap_sync #(
  parameter int WIDTH = 10
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule : rspc_strap_sync

// ---- hdl/rspc_config.sv ----
`timescale 1ns/1ps
// Overview of operation
// - straps endian, address 22:19, eeprom, host width sampled during reset and latched
// - endian strap 0 big-endian, 1 little-endian, little is default
// - boot mode 00 none, 01 host or pci per pci strap, 11 ext memory
// - ext memory clock 00 input clock, 01 cpu/4, 10 cpu/6, 11 reserved
// - eeprom strap 1 with pci enabled loads pci from eeprom, else defaults
// - pci speed strap 0 gives 66 MHz, 1 gives 33 MHz, only with pci
// - host width 0 gives 16-bit port, upper pins hi-z; 1 gives 32-bit
// - pci/mac straps 00 host, 01 mac plus 16-bit or no host, 10 pci
// - registers in 4K region at 0x01b3f000, reached over config bus
// - bits 31:7 of peripheral select reserved, fixed read, writes ignored
// - bit 6 enables video port 2; 0 disables and powers it down
// - pci strap 1 disables host port; shared pins act as pci only when mac strap is 0
module rspc_config
  import rspc_pkg::*;
#(
  parameter logic [31:0] SCAN_ID_VALUE = 32'h00000001 // arbitrary identity value
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic endian_strap_in,
  input wire logic [3:0] ext_mem_address_in,
  input wire logic pci_eeprom_autoinit_strap_in,
  input wire logic pci_speed_strap_in,
  input wire logic host_width_strap_in,
  input wire logic mac_enable_strap_in,
  input wire logic pci_enable_strap_in,
  input wire logic cfg_sel_in,
  input wire logic cfg_wr_in,
  input wire logic [31:0] cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  output logic endian_select_out,
  output logic [1:0] boot_mode_out,
  output logic boot_from_pci_out,
  output logic [1:0] ext_mem_clock_select_out,
  output logic ext_mem_clk_input_sel_out,
  output logic ext_mem_clk_div4_sel_out,
  output logic ext_mem_clk_div6_sel_out,
  output logic pci_enable_out,
  output logic pci_eeprom_load_out,
  output logic pci_speed_33_out,
  output logic host_port_enable_out,
  output logic host_port_32bit_out,
  output logic host_data_upper_oe_out,
  output logic ethernet_mac_enable_out,
  output logic shared_pins_pci_out,
  output logic video_port2_enable_out
);
  // ************************************************************
  // strap capture
  // ************************************************************
  // pins are asynchronous, so sample after two flops
  logic [9:0] strap_sync;
  logic [9:0] strap_r;
  logic [9:0] strap_nxt;

  rspc_strap_sync #(
    .WIDTH(10)
  ) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({pci_enable_strap_in, mac_enable_strap_in, host_width_strap_in, pci_speed_strap_in,
      pci_eeprom_autoinit_strap_in, ext_mem_address_in, endian_strap_in}),
    .sync_out(strap_sync)
  );

  // follow pins only while reset held; frozen once released
  assign strap_nxt = reset_in ? strap_sync : strap_r;

  always_ff @(posedge clk_in) begin
    strap_r <= strap_nxt;
  end

  // ************************************************************
  // strap decode
  // ************************************************************
  wire endian_w = strap_r[RSPC_ST_ENDIAN_BIT];
  wire [1:0] boot_w = strap_r[RSPC_ST_BOOT_LSB+1:RSPC_ST_BOOT_LSB];
  wire [1:0] clk_w = strap_r[RSPC_ST_CLK_LSB+1:RSPC_ST_CLK_LSB];
  wire eeai_w = strap_r[RSPC_ST_EEAI_BIT];
  wire speed_w = strap_r[RSPC_ST_SPEED_BIT];
  wire width_w = strap_r[RSPC_ST_WIDTH_BIT];
  wire [1:0] sel_w = {strap_r[RSPC_ST_PCI_BIT], strap_r[RSPC_ST_MAC_BIT]};
  wire pci_on = (sel_w == RSPC_SEL_PCI);
  wire mac_on = (sel_w == RSPC_SEL_MAC);
  wire host_on = (sel_w == RSPC_SEL_HOST) || (mac_on && !width_w);

  assign endian_select_out = endian_w;
  assign boot_mode_out = boot_w;
  assign boot_from_pci_out = (boot_w == RSPC_BOOT_HOST_PCI) && pci_on;
  assign ext_mem_clock_select_out = clk_w;
  assign ext_mem_clk_input_sel_out = (clk_w == RSPC_CLK_INPUT);
  assign ext_mem_clk_div4_sel_out = (clk_w == RSPC_CLK_DIV4);
  assign ext_mem_clk_div6_sel_out = (clk_w == RSPC_CLK_DIV6);
  assign pci_enable_out = pci_on;
  assign pci_eeprom_load_out = pci_on && eeai_w;
  // speed strap ignored while pci is off
  assign pci_speed_33_out = pci_on && speed_w;
  assign host_port_enable_out = host_on && !pci_on;
  // 32-bit only in plain host selection; mac owns the upper lanes
  assign host_port_32bit_out = (sel_w == RSPC_SEL_HOST) && width_w;
  assign host_data_upper_oe_out = host_port_32bit_out;
  assign ethernet_mac_enable_out = mac_on;
  assign shared_pins_pci_out = pci_on;

  // ************************************************************
  // config bus registers
  // ************************************************************
  logic vp2_en_r;
  logic vp2_en_nxt;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  wire in_region = (cfg_addr_in >= RSPC_REGION_BASE) &&
    (cfg_addr_in < RSPC_REGION_BASE + RSPC_REGION_SIZE);
  wire [11:0] ofs_w = cfg_addr_in[11:0];
  wire hit_psel = cfg_sel_in && in_region && (ofs_w == RSPC_PERIPH_SEL_OFS);
  wire hit_stat = cfg_sel_in && in_region && (ofs_w == RSPC_DEV_STATUS_OFS);
  wire hit_id = cfg_sel_in && in_region && (ofs_w == RSPC_SCAN_ID_OFS);

  // only bit 6 is writable; reserved bits never stored
  assign vp2_en_nxt = (hit_psel && cfg_wr_in) ? cfg_wdata_in[RSPC_VP2_EN_BIT] : vp2_en_r;

  wire [31:0] psel_rd = RSPC_RSVD_READ_VAL | ({31'h0, vp2_en_r} << RSPC_VP2_EN_BIT);
  wire [31:0] stat_rd = {22'h0, strap_r};

  // unmapped offsets read zero, writes dropped
  assign rdata_nxt = (!cfg_sel_in || cfg_wr_in) ? rdata_r :
    hit_psel ? psel_rd :
    hit_stat ? stat_rd :
    hit_id ? SCAN_ID_VALUE : 32'h0;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vp2_en_r <= RSPC_VP2_EN_RST;
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      vp2_en_r <= vp2_en_nxt;
      ack_r <= cfg_sel_in;
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg_rdata_out = rdata_r;
  assign cfg_ack_out = ack_r;
  assign video_port2_enable_out = vp2_en_r;
endmodule : rspc_config

// ---- sim/rspc_config_asserts.sv ----
`timescale 1ns/1ps
module rspc_config_asserts
  import rspc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cfg_sel_in,
  input wire logic cfg_wr_in,
  input wire logic [31:0] cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_ack_out,
  input wire logic [1:0] boot_mode_out,
  input wire logic boot_from_pci_out,
  input wire logic [1:0] ext_mem_clock_select_out,
  input wire logic ext_mem_clk_div6_sel_out,
  input wire logic pci_enable_out,
  input wire logic pci_eeprom_load_out,
  input wire logic pci_speed_33_out,
  input wire logic host_port_enable_out,
  input wire logic host_port_32bit_out,
  input wire logic host_data_upper_oe_out,
  input wire logic shared_pins_pci_out,
  input wire logic video_port2_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_wr; cfg_sel_in && cfg_wr_in && cfg_addr_in == RSPC_REGION_BASE; endsequence
  sequence s_rd; cfg_sel_in && !cfg_wr_in && cfg_addr_in == RSPC_REGION_BASE; endsequence
  a_ack_pulse: assert property (cfg_sel_in |=> cfg_ack_out) else $error("ack missing");
  a_ack_cause: assert property (cfg_ack_out |-> $past(cfg_sel_in)) else $error("stray ack");
  a_vp2_write: assert property (s_wr |=> video_port2_enable_out == $past(cfg_wdata_in[RSPC_VP2_EN_BIT]))
    else $error("vp2 write");
  a_vp2_hold: assert property (!(cfg_sel_in && cfg_wr_in && cfg_addr_in == RSPC_REGION_BASE)
    |=> $stable(video_port2_enable_out)) else $error("vp2 moved");
  a_rd_layout: assert property (s_rd |=> cfg_rdata_out == {25'h0, video_port2_enable_out, 6'h0})
    else $error("select read");
  a_unmapped_zero: assert property (cfg_sel_in && !cfg_wr_in && cfg_addr_in[31:12] != RSPC_REGION_BASE[31:12]
    |=> cfg_rdata_out == RSPC_RSVD_READ_VAL) else $error("unmapped read");
  a_straps_frozen: assert property (!$past(reset_in)
    |-> $stable({pci_enable_out, host_port_32bit_out, ext_mem_clock_select_out})) else $error("strap moved");
  a_pci_only: assert property (pci_speed_33_out || pci_eeprom_load_out |-> pci_enable_out) else $error("pci gate");
  a_pci_host: assert property (pci_enable_out |-> !host_port_enable_out && shared_pins_pci_out)
    else $error("pci host");
  a_width_oe: assert property (host_data_upper_oe_out == host_port_32bit_out
    && (!host_port_32bit_out || host_port_enable_out)) else $error("width");
  a_clk_div6: assert property (ext_mem_clk_div6_sel_out == (ext_mem_clock_select_out == RSPC_CLK_DIV6))
    else $error("clk decode");
  a_boot_pci: assert property (boot_from_pci_out == (pci_enable_out && boot_mode_out == RSPC_BOOT_HOST_PCI))
    else $error("boot gate");
endmodule : rspc_config_asserts
bind rspc_config rspc_config_asserts u_chk (.clk_in, .reset_in, .cfg_sel_in, .cfg_wr_in, .cfg_addr_in,
  .cfg_wdata_in, .cfg_rdata_out, .cfg_ack_out, .boot_mode_out, .boot_from_pci_out,
  .ext_mem_clock_select_out, .ext_mem_clk_div6_sel_out,
  .pci_enable_out, .pci_eeprom_load_out, .pci_speed_33_out, .host_port_enable_out, .host_port_32bit_out,
  .host_data_upper_oe_out, .shared_pins_pci_out, .video_port2_enable_out);

// ---- sim/rspc_board_straps.sv ----
`timescale 1ns/1ps
module rspc_board_straps (
  input wire logic [9:0] pull_in,
  output logic [9:0] strap_out
);
  // board never fits the speed pull-up without pci
  assign strap_out = {pull_in[9:7], pull_in[6] & pull_in[9], pull_in[5:0]};
endmodule : rspc_board_straps

// ---- sim/tb_rspc_config.sv ----
`timescale 1ns/1ps
module tb_rspc_config import rspc_pkg::*;;
  logic clk_in = 0, reset_in = 1, sel = 0, wr = 0;
  logic [31:0] addr = 0, wdata = 0, rdata, w;
  logic ack;
  logic [9:0] pull = 0, st, s;
  logic [17:0] o;
  logic [32:0] e;
  logic [32:0] expq[$];
  int fails = 0, comparisons = 0, cycles = 0, seed = 32'hef72;
  rspc_board_straps board (.pull_in(pull), .strap_out(st));
  rspc_config dut (.clk_in(clk_in), .reset_in(reset_in), .endian_strap_in(st[0]), .ext_mem_address_in(st[4:1]),
    .pci_eeprom_autoinit_strap_in(st[5]), .pci_speed_strap_in(st[6]), .host_width_strap_in(st[7]),
    .mac_enable_strap_in(st[8]), .pci_enable_strap_in(st[9]), .cfg_sel_in(sel), .cfg_wr_in(wr),
    .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .cfg_ack_out(ack),
    .endian_select_out(o[0]), .boot_mode_out(o[2:1]), .boot_from_pci_out(o[3]), .ext_mem_clock_select_out(o[5:4]),
    .ext_mem_clk_input_sel_out(o[6]), .ext_mem_clk_div4_sel_out(o[7]), .ext_mem_clk_div6_sel_out(o[8]),
    .pci_enable_out(o[9]), .pci_eeprom_load_out(o[10]), .pci_speed_33_out(o[11]), .host_port_enable_out(o[12]),
    .host_port_32bit_out(o[13]), .host_data_upper_oe_out(o[14]), .ethernet_mac_enable_out(o[15]),
    .shared_pins_pci_out(o[16]), .video_port2_enable_out(o[17]));
  // ************************************************************
  // checking and access tasks
  // ************************************************************
  task close_out;
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // second edge keeps the strobe from being driven twice in one step
  task acc(input logic wi, input logic [31:0] a, input logic [31:0] d, input logic [31:0] x);
    sel <= 1;
    wr <= wi;
    addr <= a;
    wdata <= d;
    expq.push_back({~wi, x});
    @(posedge clk_in);
    sel <= 0;
    @(posedge clk_in);
  endtask : acc
  function automatic logic [16:0] exp_dec(input logic [9:0] v);
    logic pe, mc, h0;
    pe = v[9] & ~v[8];
    mc = ~v[9] & v[8];
    h0 = ~v[9] & ~v[8];
    return {pe, mc, h0 & v[7], h0 & v[7], h0 | (mc & ~v[7]), pe & v[6], pe & v[5], pe, v[2:1] == 2'h2,
      v[2:1] == 2'h1, v[2:1] == 2'h0, v[2:1], v[4:3] == 2'h1 && pe, v[4:3], v[0]};
  endfunction : exp_dec
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      close_out;
    end
  end
  always @(posedge clk_in) begin
    if (ack === 1'b1) begin
      if (expq.size() == 0) chk("stray ack", 32'h0, 32'h1);
      else begin
        e = expq.pop_front();
        if (e[32]) chk("rdata", e[31:0], rdata);
      end
    end
  end
  initial begin
    repeat (24) begin
      reset_in <= 1;
      // first pass fixed: pci boot, cpu/6 clock, eeprom load, 33 MHz
      pull <= (cycles == 0) ? 10'h2ed : 10'($random(seed));
      repeat (5) @(posedge clk_in);
      s = st;
      reset_in <= 0;
      @(posedge clk_in);
      acc(1'b0, RSPC_REGION_BASE, 32'h0, 32'h0);
      pull <= ~pull;
      acc(1'b0, RSPC_REGION_BASE + 32'h4, 32'h0, {22'h0, s});
      w = $random(seed);
      acc(1'b1, RSPC_REGION_BASE, w, 32'h0);
      chk("vp2 pin", {31'h0, w[6]}, {31'h0, o[17]});
      acc(1'b1, RSPC_REGION_BASE + 32'h4, 32'hffffffff, 32'h0);
      acc(1'b0, RSPC_REGION_BASE, 32'h0, {25'h0, w[6], 6'h0});
      acc(1'b0, RSPC_REGION_BASE + 32'hc, 32'h0, 32'h0);
      acc(1'b0, 32'h01b40000, 32'h0, 32'h0);
      chk("decodes", {15'h0, exp_dec(s)}, {15'h0, o[16:0]});
    end
    // let the last acknowledge drain before counting leftovers
    @(posedge clk_in);
    chk("pending acks", 32'h0, 32'(expq.size()));
    close_out;
  end
endmodule : tb_rspc_config
